// file: logic/ssc_defines.svh
// Constants shared by both ends of the spindle speed serial control link.
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_WORD_BITS 24
`define SSC_BIT_SPIN_DIS 23
`define SSC_BIT_ACT_DIS 22
`define SSC_BIT_PARK 21
`define SSC_BIT_FLL_EN 20
`define SSC_POLE_HI 19
`define SSC_POLE_LO 18
`define SSC_DIV_HI 17
`define SSC_DIV_LO 0
`define SSC_CTRL_RESET 24'h000000
`define SSC_SCK_HALF 2
`define SSC_OFS_DATA 4'h0
`define SSC_OFS_CMD 4'h4
`define SSC_OFS_STATUS 4'h8
`define SSC_CMD_SEND 0
`define SSC_CMD_CLEAR 1
`endif

// file: logic/ssc_pkg.sv
// Types for the spindle speed serial control link: pole select for the drive, frame states for the controller.
package ssc_pkg;
    typedef enum logic [1:0] {SSC_POLE4, SSC_POLE6, SSC_POLE8, SSC_POLE12} ssc_pole_t;
    typedef enum {SSC_IDLE, SSC_CLEAR, SSC_LOW, SSC_HIGH, SSC_LOAD} ssc_host_st_t;
endpackage

// file: logic/ssc_if.sv
// Three-wire serial port plus clearing reset between controller and drive.
`timescale 1ns/1ns
interface ssc_if;
    logic sclk;
    logic sdata;
    logic load_en_n;
    logic sreset;
    modport host (output sclk, output sdata, output load_en_n, output sreset);
    modport dev (input sclk, input sdata, input load_en_n, input sreset);
endinterface

// file: logic/ssc_device.sv
// Drive end: serial control register and frequency-locked speed loop.
//
// Operation
// R01 - Load enable high: serial pins ignored
// R02 - Enable low: shift one bit per falling clock
// R03 - LSB first, bit 23 last, ends bit 0
// R04 - Enable rise copies shift register into control
// R05 - Serial reset high clears both registers
// R06 - Power events never clear serial registers
// R07 - Host may park clock high or low
// R08 - Bit 23 disables spindle
// R09 - Bit 22 disables actuator
// R10 - Bit 21 OR retract pin requests park
// R11 - Bit 20 closes loop, else pump floats
// R12 - Bits 19:18 select 4/6/8/12 pole pairs
// R13 - Bits 17:0 divide reference by eight times
// R14 - Host computes factor from oscillator and rpm
// R15 - Tacho divided to one pulse per revolution
// R16 - Feedback synchronised to reference oscillator
// R17 - Frequency error drives charge pump up/down
// R18 - At power-up loop filter driven high
// R19 - Source and divider changes need no synchronisation
// R20 - Host changes factor while revolution pulse high
// R21 - After retraction interval, brake starts automatically
// R22 - Tacho falls at zero crossing, rises commutating
// R23 - Control word crosses domains coherently
`timescale 1ns/1ns
`include "ssc_defines.svh"
module ssc_device
    import ssc_pkg::*;
#(
    parameter int DIV_W = 18
) (
    input wire logic ref_osc_clk,
    input wire logic arst_n,
    ssc_if.dev link,
    input wire logic zero_cross,
    input wire logic commutate,
    input wire logic retract_n,
    input wire logic retract_timer_pin,
    input wire logic speed_feedback_in,
    output logic tacho_out,
    output logic rev_pulse,
    output logic spindle_en,
    output logic actuator_en,
    output logic park_req,
    output logic brake_on,
    output logic pump_up,
    output logic pump_down,
    output logic pump_oe_n,
    output logic [`SSC_WORD_BITS-1:0] drive_control_word
);
    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain. The link clock may stop anywhere outside a frame,
    // so nothing here relies on a free-running edge.
    logic [`SSC_WORD_BITS-1:0] shift_q;
    logic [`SSC_WORD_BITS-1:0] ctrl_q;
    logic ctrl_tog_q;

    // Shift on falling clock only while enabled; enable high freezes it. [R01] [R02] [R07]
    always_ff @(negedge link.sclk or posedge link.sreset) begin
        if (link.sreset) begin
            shift_q <= `SSC_CTRL_RESET; // [R05]
        end else if (!link.load_en_n) begin
            shift_q <= {link.sdata, shift_q[`SSC_WORD_BITS-1:1]}; // [R03]
        end
    end

    // Only the serial reset clears these; arst_n (power events) never does. [R06]
    always_ff @(posedge link.load_en_n or posedge link.sreset) begin
        if (link.sreset) begin
            ctrl_q <= `SSC_CTRL_RESET; // [R05]
            ctrl_tog_q <= 1'b0;
        end else begin
            ctrl_q <= shift_q; // [R04]
            ctrl_tog_q <= ~ctrl_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing: ctrl_q is stable long after the toggle moves, so the word is
    // taken whole when the synchronised toggle changes. [R23] [R19]
    logic tog_s1_q, tog_s2_q, tog_s3_q, rst_s1_q, rst_s2_q;
    logic [`SSC_WORD_BITS-1:0] word_q, word_d;
    always_ff @(posedge ref_osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            tog_s1_q <= ctrl_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            rst_s1_q <= link.sreset;
            rst_s2_q <= rst_s1_q;
        end
    end

    always_comb begin
        word_d = word_q;
        if (rst_s2_q) begin
            word_d = `SSC_CTRL_RESET; // [R05]
        end else if (tog_s2_q != tog_s3_q) begin
            word_d = ctrl_q; // [R23]
        end
    end

    always_ff @(posedge ref_osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_q <= `SSC_CTRL_RESET;
        end else begin
            word_q <= word_d;
        end
    end

    assign drive_control_word = word_q;
    assign spindle_en = ~word_q[`SSC_BIT_SPIN_DIS]; // [R08]
    assign actuator_en = ~word_q[`SSC_BIT_ACT_DIS]; // [R09]
    assign park_req = word_q[`SSC_BIT_PARK] | ~retract_n; // [R10]

    ////////////////////////////////////////////////////////////////////////
    // Tacho and revolution pulse. [R22] [R15]
    logic tacho_q, tacho_d, rev_q, rev_d;
    logic [3:0] edge_cnt_q, edge_cnt_d;
    function automatic logic [3:0] pole_count(input logic [1:0] sel); // [R12]
        case (ssc_pole_t'(sel))
            SSC_POLE4: pole_count = 4'h4;
            SSC_POLE6: pole_count = 4'h6;
            SSC_POLE8: pole_count = 4'h8;
            SSC_POLE12: pole_count = 4'hc;
            default: pole_count = 4'h4;
        endcase
    endfunction

    // One tacho period per commutation; pole-pairs periods per half rev.
    always_comb begin
        tacho_d = tacho_q;
        rev_d = rev_q;
        edge_cnt_d = edge_cnt_q;
        if (zero_cross) begin
            tacho_d = 1'b0;
        end else if (commutate) begin
            tacho_d = 1'b1;
        end
        if (commutate && !tacho_q) begin
            if (edge_cnt_q >= pole_count(word_q[`SSC_POLE_HI:`SSC_POLE_LO]) - 4'h1) begin
                edge_cnt_d = 4'h0;
                rev_d = ~rev_q;
            end else begin
                edge_cnt_d = edge_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            tacho_q <= 1'b0;
            rev_q <= 1'b0;
            edge_cnt_q <= 4'h0;
        end else begin
            tacho_q <= tacho_d;
            rev_q <= rev_d;
            edge_cnt_q <= edge_cnt_d;
        end
    end
    assign tacho_out = tacho_q;
    assign rev_pulse = rev_q;

    ////////////////////////////////////////////////////////////////////////
    // Frequency-locked loop: count reference ticks between feedback rises
    // and compare with 8 * divider. [R16] [R17] [R13]
    logic fb_s1_q, fb_s2_q, fb_s3_q, seen_q, seen_d;
    logic [DIV_W+3:0] per_q, per_d;
    logic up_q, up_d, dn_q, dn_d;
    logic [DIV_W+3:0] target;
    assign target = {1'b0, word_q[`SSC_DIV_HI:`SSC_DIV_LO], 3'b000};

    always_comb begin
        per_d = per_q;
        up_d = up_q;
        dn_d = dn_q;
        seen_d = seen_q;
        if (fb_s2_q && !fb_s3_q) begin
            // The rise that opens a period counts as its first tick, so an exact period equals the target.
            per_d = {{(DIV_W+3){1'b0}}, 1'b1};
            seen_d = 1'b1;
            // Short period means too fast: pump down; long means pump up.
            up_d = seen_q && (per_q > target);
            dn_d = seen_q && (per_q < target);
        end else if (per_q != '1) begin
            per_d = per_q + 1'b1;
        end
        // Until a first feedback rise is seen, drive full current. [R18]
        if (!seen_q) begin
            up_d = 1'b1;
            dn_d = 1'b0;
        end
    end

    always_ff @(posedge ref_osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            fb_s1_q <= 1'b0;
            fb_s2_q <= 1'b0;
            fb_s3_q <= 1'b0;
            per_q <= '0;
            up_q <= 1'b1;
            dn_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            fb_s1_q <= speed_feedback_in;
            fb_s2_q <= fb_s1_q;
            fb_s3_q <= fb_s2_q;
            per_q <= per_d;
            up_q <= up_d;
            dn_q <= dn_d;
            seen_q <= seen_d;
        end
    end

    assign pump_oe_n = ~word_q[`SSC_BIT_FLL_EN] & seen_q; // [R11] [R18]
    assign pump_up = up_q & ~pump_oe_n; // [R17]
    assign pump_down = dn_q & ~pump_oe_n; // [R17]

    ////////////////////////////////////////////////////////////////////////
    // Retract interval ends when the external timer pin falls. [R21]
    logic brake_q, brake_d, tmr_q;
    always_comb begin
        brake_d = brake_q;
        if (!park_req) begin
            brake_d = 1'b0;
        end else if (tmr_q && !retract_timer_pin) begin
            brake_d = 1'b1;
        end
    end
    always_ff @(posedge ref_osc_clk or negedge arst_n) begin
        if (!arst_n) begin
            brake_q <= 1'b0;
            tmr_q <= 1'b0;
        end else begin
            brake_q <= brake_d;
            tmr_q <= retract_timer_pin;
        end
    end
    assign brake_on = brake_q;
endmodule // ssc_device

// file: logic/ssc_host.sv
// Controller end: Avalon-MM slave that shifts control words onto the link.
`timescale 1ns/1ns
`include "ssc_defines.svh"
module ssc_host
    import ssc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    ssc_if.host link
);
    ssc_host_st_t st_q, st_d;
    logic [`SSC_WORD_BITS-1:0] data_q, data_d, sh_q, sh_d;
    logic [4:0] bit_q, bit_d;
    logic [3:0] half_q, half_d;
    logic [31:0] rd_q, rd_d;
    logic ack_q, ack_d;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Writes while busy are held off by waitrequest rather than dropped.
    always_comb begin
        st_d = st_q;
        data_d = data_q;
        sh_d = sh_q;
        bit_d = bit_q;
        half_d = half_q;
        rd_d = rd_q;
        ack_d = 1'b0;
        if ((avs_read || avs_write) && !ack_q) begin
            if (avs_read) begin
                ack_d = 1'b1;
                case (avs_address)
                    `SSC_OFS_DATA: rd_d = {8'h00, data_q};
                    `SSC_OFS_STATUS: rd_d = {31'h0, st_q != SSC_IDLE};
                    default: rd_d = 32'h0;
                endcase
            end else if (st_q == SSC_IDLE) begin
                ack_d = 1'b1;
                if (avs_address == `SSC_OFS_DATA) begin
                    data_d = avs_writedata[`SSC_WORD_BITS-1:0];
                end else if (avs_address == `SSC_OFS_CMD && avs_writedata[`SSC_CMD_CLEAR]) begin
                    st_d = SSC_CLEAR;
                    half_d = 4'h0;
                end else if (avs_address == `SSC_OFS_CMD && avs_writedata[`SSC_CMD_SEND]) begin
                    st_d = SSC_HIGH;
                    sh_d = data_q;
                    bit_d = 5'd0;
                    half_d = 4'h0;
                end
            end
        end
        case (st_q)
            SSC_IDLE: begin
            end
            SSC_CLEAR: begin
                half_d = half_q + 4'h1;
                if (half_q == 4'(`SSC_SCK_HALF)) begin
                    st_d = SSC_IDLE;
                end
            end
            SSC_HIGH: begin
                half_d = half_q + 4'h1;
                if (half_q == 4'(`SSC_SCK_HALF)) begin
                    half_d = 4'h0;
                    st_d = SSC_LOW;
                end
            end
            SSC_LOW: begin
                half_d = half_q + 4'h1;
                if (half_q == 4'(`SSC_SCK_HALF)) begin
                    half_d = 4'h0;
                    sh_d = {1'b0, sh_q[`SSC_WORD_BITS-1:1]}; // [R03]
                    bit_d = bit_q + 5'd1;
                    st_d = (bit_q == 5'(`SSC_WORD_BITS - 1)) ? SSC_LOAD : SSC_HIGH;
                end
            end
            SSC_LOAD: begin
                half_d = half_q + 4'h1;
                if (half_q == 4'(`SSC_SCK_HALF)) begin
                    st_d = SSC_IDLE;
                end
            end
            default: st_d = SSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= SSC_IDLE;
            data_q <= `SSC_CTRL_RESET;
            sh_q <= `SSC_CTRL_RESET;
            bit_q <= 5'd0;
            half_q <= 4'h0;
            rd_q <= 32'h0;
            ack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            data_q <= data_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            half_q <= half_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
        end
    end

    // Clock parks low; device samples data on the falling edge. [R07]
    assign avs_readdata = rd_q;
    assign link.sclk = (st_q == SSC_HIGH);
    assign link.sdata = sh_q[0]; // [R03]
    assign link.load_en_n = !(st_q == SSC_HIGH || st_q == SSC_LOW);
    assign link.sreset = (st_q == SSC_CLEAR);
endmodule // ssc_host

// file: testbench/ssc_link_sva.sv
// Checker for the serial link and the drive outputs that it controls.
`timescale 1ns/1ns
`include "ssc_defines.svh"
module ssc_link_sva (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_en_n,
    input wire logic sreset,
    input wire logic retract_n,
    input wire logic [`SSC_WORD_BITS-1:0] drive_control_word,
    input wire logic spindle_en,
    input wire logic actuator_en,
    input wire logic park_req,
    input wire logic pump_up,
    input wire logic pump_oe_n
);
    logic [4:0] falls_q, falls_d;
    logic [3:0] since_q, since_d;
    logic [`SSC_WORD_BITS-1:0] sh_q, sh_d;
    logic sclk_q, ld_q, fall;
    // A shadow of the drive's shift register, built from the wire alone.
    always_comb begin
        fall = sclk_q & ~sclk & ~load_en_n;
        falls_d = load_en_n ? 5'h00 : falls_q + {4'h0, fall};
        sh_d = fall ? {sdata, sh_q[`SSC_WORD_BITS-1:1]} : sh_q;
        since_d = (sreset | (load_en_n & ~ld_q)) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            falls_q <= 5'h00;
            since_q <= 4'h0;
            sh_q <= '0;
            sclk_q <= 1'b0;
            ld_q <= 1'b1;
        end else begin
            falls_q <= falls_d;
            since_q <= since_d;
            sh_q <= sh_d;
            sclk_q <= sclk;
            ld_q <= load_en_n;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    a_spin_enable: assert property (spindle_en == !drive_control_word[`SSC_BIT_SPIN_DIS])
        else $error("Spindle enable does not follow the control word.");
    a_act_enable: assert property (actuator_en == !drive_control_word[`SSC_BIT_ACT_DIS])
        else $error("Actuator enable does not follow the control word.");
    a_park_or: assert property (park_req == (drive_control_word[`SSC_BIT_PARK] | !retract_n))
        else $error("Park request is not the OR of its sources.");
    a_powerup_pump: assert property ($rose(arst_n) |-> pump_up && !pump_oe_n)
        else $error("Loop filter not driven high at power-up.");
    a_frame_len: assert property ($rose(load_en_n) |-> falls_q == 5'h18)
        else $error("Frame did not carry 24 clock falls.");
    a_word_loaded: assert property ($rose(load_en_n) |-> ##[1:6] drive_control_word == sh_q)
        else $error("Control word differs from the shifted bits.");
    a_word_hold: assert property ($changed(drive_control_word) |-> since_q <= 4'h6)
        else $error("Control word changed away from a load or clear.");
    a_sreset_clear: assert property ($rose(sreset) |-> ##[1:8] drive_control_word == '0)
        else $error("Serial reset did not clear the control word.");
    a_sclk_parked: assert property (load_en_n |-> !sclk)
        else $error("Serial clock not parked outside a frame.");
    c_load: cover property ($rose(load_en_n));
    c_clear: cover property ($rose(sreset));
    c_pin_park: cover property (park_req && retract_n == 1'b0);
endmodule // ssc_link_sva

// file: testbench/spindle_speed_serial_ctrl_tb.sv
// Self-checking bench joining controller and drive ends over the serial link.
`timescale 1ns/1ns
`include "ssc_defines.svh"
module spindle_speed_serial_ctrl_tb;
    typedef struct packed {logic [23:0] word; logic spin; logic act; logic park;} ssc_row_t;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, tacho_out, spindle_en, actuator_en, park_req, pump_up, pump_oe_n;
    logic rev_pulse, brake_on, pump_down;
    logic zero_cross = 1'b0, commutate = 1'b0, retract_n = 1'b1, speed_feedback_in = 1'b0;
    logic retract_timer_pin = 1'b1;
    logic [`SSC_WORD_BITS-1:0] drive_control_word;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    ssc_row_t rows [6] = '{'{24'h000001, 1'b1, 1'b1, 1'b0}, '{24'h840000, 1'b0, 1'b1, 1'b0},
        '{24'h4bffff, 1'b1, 1'b0, 1'b0}, '{24'h3c0000, 1'b1, 1'b1, 1'b1},
        '{24'hffffff, 1'b0, 1'b0, 1'b1}, '{24'h5a5a5a, 1'b1, 1'b0, 1'b0}};
    always #50 core_clk = ~core_clk;
    ssc_if ssc_if_inst ();
    ssc_host ssc_host_inst (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(ssc_if_inst.host));
    ssc_device ssc_device_inst (.ref_osc_clk(core_clk), .arst_n(arst_n), .link(ssc_if_inst.dev),
        .zero_cross(zero_cross), .commutate(commutate), .retract_n(retract_n),
        .retract_timer_pin(retract_timer_pin), .speed_feedback_in(speed_feedback_in), .tacho_out(tacho_out),
        .rev_pulse(rev_pulse), .spindle_en(spindle_en), .actuator_en(actuator_en), .park_req(park_req),
        .brake_on(brake_on), .pump_up(pump_up), .pump_down(pump_down),
        .pump_oe_n(pump_oe_n), .drive_control_word(drive_control_word));
    ssc_link_sva ssc_link_sva_inst (.core_clk(core_clk), .arst_n(arst_n), .sclk(ssc_if_inst.sclk),
        .sdata(ssc_if_inst.sdata), .load_en_n(ssc_if_inst.load_en_n), .sreset(ssc_if_inst.sreset),
        .retract_n(retract_n), .drive_control_word(drive_control_word), .spindle_en(spindle_en),
        .actuator_en(actuator_en), .park_req(park_req), .pump_up(pump_up), .pump_oe_n(pump_oe_n));
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        avs_write <= 1'b0;
    endtask
    task automatic av_rd(input logic [3:0] a);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
    endtask
    // Polls busy rather than counting cycles, so a slower frame clock still works.
    task automatic send(input logic [23:0] w);
        av_wr(`SSC_OFS_DATA, {8'h00, w});
        av_wr(`SSC_OFS_CMD, 32'h1);
        do av_rd(`SSC_OFS_STATUS); while (rd[0] !== 1'b0);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        check("pump_up", 24'(pump_up), 24'h1);
        check("pump_oe_n", 24'(pump_oe_n), 24'h0);
        // The serial registers power up unknown, so clear them first.
        av_wr(`SSC_OFS_CMD, 32'h2);
        repeat (8) @(posedge core_clk);
        check("cleared_word", drive_control_word, 24'h0);
        // Four commutations at four pole pairs raise the revolution pulse; divider changes follow while high.
        for (int n = 0; n < 4; n++) begin
            @(posedge core_clk);
            zero_cross <= 1'b1;
            @(posedge core_clk);
            zero_cross <= 1'b0;
            commutate <= 1'b1;
            @(posedge core_clk);
            commutate <= 1'b0;
        end
        @(negedge core_clk);
        check("rev_pulse", 24'(rev_pulse), 24'h1);
        for (int i = 0; i < 6; i++) begin
            send(rows[i].word);
            check("control_word", drive_control_word, rows[i].word);
            check("spindle_en", 24'(spindle_en), 24'(rows[i].spin));
            check("actuator_en", 24'(actuator_en), 24'(rows[i].act));
            check("park_req", 24'(park_req), 24'(rows[i].park));
        end
        av_rd(`SSC_OFS_DATA);
        check("data_readback", rd[23:0], 24'h5a5a5a);
        av_rd(4'hc);
        check("unmapped_read", rd[23:0], 24'h0);
        @(posedge core_clk);
        retract_n <= 1'b0;
        @(negedge core_clk);
        check("pin_park", 24'(park_req), 24'h1);
        @(posedge core_clk);
        retract_timer_pin <= 1'b0;
        repeat (2) @(negedge core_clk);
        check("brake_on", 24'(brake_on), 24'h1);
        @(posedge core_clk);
        retract_timer_pin <= 1'b1;
        retract_n <= 1'b1;
        zero_cross <= 1'b1;
        @(posedge core_clk);
        zero_cross <= 1'b0;
        repeat (2) @(negedge core_clk);
        check("tacho_fall", 24'(tacho_out), 24'h0);
        @(posedge core_clk);
        commutate <= 1'b1;
        @(posedge core_clk);
        commutate <= 1'b0;
        repeat (2) @(negedge core_clk);
        check("tacho_rise", 24'(tacho_out), 24'h1);
        // Second word is written while the first frame is still on the wire.
        av_wr(`SSC_OFS_DATA, 32'h003c0000);
        av_wr(`SSC_OFS_CMD, 32'h1);
        // Divider field 1 asks for eight ticks per feedback period, as 7.5 * ref / rpm gives.
        send(24'h940001);
        check("back_to_back", drive_control_word, 24'h940001);
        // A six-tick feedback period is too fast, so the pump must discharge.
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            speed_feedback_in <= ~speed_feedback_in;
            repeat (2) @(posedge core_clk);
        end
        @(negedge core_clk);
        check("pump_down", 24'(pump_down), 24'h1);
        repeat (12) @(posedge core_clk);
        speed_feedback_in <= 1'b1;
        repeat (5) @(negedge core_clk);
        check("pump_up_slow", 24'(pump_up), 24'h1);
        send(24'h000001);
        check("pump_float", 24'(pump_oe_n), 24'h1);
        // A power reset must leave the serial control register alone.
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        check("ctrl_kept", ssc_device_inst.ctrl_q, 24'h000001);
        check("pump_up_again", 24'(pump_up), 24'h1);
        av_wr(`SSC_OFS_CMD, 32'h2);
        repeat (8) @(posedge core_clk);
        check("midrun_clear", drive_control_word, 24'h0);
        print_verdict();
    end
endmodule // spindle_speed_serial_ctrl_tb
